// ===== capture_timer.sv
// capture timer with pulse generation, AHB-Lite register slave
`timescale 1ns/10ps
module capture_timer
  import capture_timer_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_b_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic [31:0]      hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        capture_input_a_i,
  input  wire logic        capture_input_b_i,
  input  wire logic        ext_count_clock_pin_i,
  output logic             pulse_out_pin_o
);
  logic [2:0]       clk_sel_q;
  logic             clr_en_q;
  logic [2:0]       cap_sel_q;
  logic             run_q;
  logic             pulse_en_q;
  logic             dbuf_en_q;
  logic             act_high_q;
  logic [CNT_W-1:0] cmp_a_q;
  logic [CNT_W-1:0] cmp_b_q;
  logic [CNT_W-1:0] buf_a_q;
  logic [CNT_W-1:0] buf_b_q;
  logic [CNT_W-1:0] cap_a_q;
  logic [CNT_W-1:0] cap_b_q;
  logic [CNT_W-1:0] count_value_q;
  logic             pulse_flipflop_q;
  logic             pulse_ff_prev_q;

  logic             wr_pend_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic             rd_pend_q;
  logic [ADDR_W-1:0] rd_addr_q;
  logic [31:0]      rdata_q;

  logic a_rise;
  logic a_fall;
  logic b_rise;
  logic ext_rise;
  logic tick;
  logic ff_rise;
  logic ff_fall;
  logic addr_ok;
  logic match_a;
  logic match_b;
  logic pin_clear;
  logic soft_cap;
  logic cap_a_ev;
  logic cap_b_ev;

  edge_sync u_sync_a (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (capture_input_a_i),
    .rise_o    (a_rise),
    .fall_o    (a_fall)
  );

  edge_sync u_sync_b (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (capture_input_b_i),
    .rise_o    (b_rise),
    .fall_o    ()
  );

  edge_sync u_sync_ext (
    .clk_sys_i (clk_sys_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (ext_count_clock_pin_i),
    .rise_o    (ext_rise),
    .fall_o    ()
  );

  prescaler u_presc (
    .clk_sys_i  (clk_sys_i),
    .rst_b_i    (rst_b_i),
    .run_i      (run_q),
    .sel_i      (clk_sel_q),
    .ext_rise_i (ext_rise),
    .tick_o     (tick)
  );

  // ---------------- bus slave: zero wait states, always OKAY
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;

  assign addr_ok = hsel_i & hready_i & htrans_i[1];

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      rd_pend_q <= 1'b0;
      rd_addr_q <= '0;
    end else begin
      wr_pend_q <= addr_ok & hwrite_i;
      rd_pend_q <= addr_ok & ~hwrite_i;
      if (addr_ok) begin
        wr_addr_q <= haddr_i[ADDR_W-1:0];
        rd_addr_q <= haddr_i[ADDR_W-1:0];
      end
    end
  end

  // read data registered in the address phase so it stands in data phase
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_q <= '0;
    end else if (addr_ok && !hwrite_i) begin
      case (haddr_i[ADDR_W-1:0])
        OFS_MODE: begin
          rdata_q <= '0;
          rdata_q[CLK_SEL_LSB +: 3] <= clk_sel_q;
          rdata_q[CLR_EN_BIT] <= clr_en_q;
          rdata_q[SOFT_CAP_BIT] <= 1'b1; // RQ6
          rdata_q[CAP_SEL_LSB +: 3] <= cap_sel_q;
        end
        OFS_CTRL: begin
          rdata_q <= '0;
          rdata_q[RUN_BIT] <= run_q;
          rdata_q[PULSE_EN_BIT] <= pulse_en_q;
          rdata_q[DBUF_EN_BIT] <= dbuf_en_q;
          rdata_q[ACT_HIGH_BIT] <= act_high_q;
          rdata_q[FF_INIT_BIT] <= pulse_flipflop_q;
        end
        OFS_CMPA: rdata_q <= {16'h0000, cmp_a_q};
        OFS_CMPB: rdata_q <= {16'h0000, cmp_b_q};
        OFS_CAPA: rdata_q <= {16'h0000, cap_a_q};
        OFS_CAPB: rdata_q <= {16'h0000, cap_b_q};
        OFS_CNT:  rdata_q <= {16'h0000, count_value_q};
        default:  rdata_q <= '0;
      endcase
    end
  end

  assign hrdata_o = rd_pend_q ? rdata_q : 32'h0000_0000;

  // ---------------- register writes
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      clk_sel_q <= MODE_RESET[CLK_SEL_LSB +: 3];
      clr_en_q <= MODE_RESET[CLR_EN_BIT];
      cap_sel_q <= MODE_RESET[CAP_SEL_LSB +: 3];
    end else if (wr_pend_q && wr_addr_q == OFS_MODE) begin
      clk_sel_q <= hwdata_i[CLK_SEL_LSB +: 3];
      clr_en_q <= hwdata_i[CLR_EN_BIT];
      cap_sel_q <= hwdata_i[CAP_SEL_LSB +: 3];
    end
  end

  // soft capture fires on a write of zero; one is ignored
  assign soft_cap = wr_pend_q && wr_addr_q == OFS_MODE
                    && !hwdata_i[SOFT_CAP_BIT]; // RQ6

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      run_q <= 1'b0;
      pulse_en_q <= 1'b0;
      dbuf_en_q <= 1'b0;
      act_high_q <= 1'b0;
    end else if (wr_pend_q && wr_addr_q == OFS_CTRL) begin
      run_q <= hwdata_i[RUN_BIT];
      pulse_en_q <= hwdata_i[PULSE_EN_BIT];
      dbuf_en_q <= hwdata_i[DBUF_EN_BIT];
      act_high_q <= hwdata_i[ACT_HIGH_BIT];
    end
  end

  // compare writes go to the buffers; unless pulse mode and double buffering are both on they
  // also land in the live compare registers at once
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      buf_a_q <= '0;
      buf_b_q <= '0;
    end else if (wr_pend_q) begin
      if (wr_addr_q == OFS_CMPA) begin
        buf_a_q <= hwdata_i[CNT_W-1:0];
      end
      if (wr_addr_q == OFS_CMPB) begin
        buf_b_q <= hwdata_i[CNT_W-1:0];
      end
    end
  end

  assign match_a = tick && count_value_q == cmp_a_q;
  assign match_b = tick && count_value_q == cmp_b_q;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmp_a_q <= '0;
      cmp_b_q <= '0;
    end else if (pulse_en_q && dbuf_en_q) begin
      if (match_b) begin
        cmp_a_q <= buf_a_q; // RQ12
        cmp_b_q <= buf_b_q; // RQ12
      end
    end else if (wr_pend_q) begin
      if (wr_addr_q == OFS_CMPA) begin
        cmp_a_q <= hwdata_i[CNT_W-1:0];
      end
      if (wr_addr_q == OFS_CMPB) begin
        cmp_b_q <= hwdata_i[CNT_W-1:0];
      end
    end
  end

  // ---------------- counter; ordering of capture vs clear is by value:
  // captures sample count_value_q before the clear takes effect
  assign pin_clear = (cap_sel_q == CAP_CLR_ON_B
                      || cap_sel_q == CAP_A_CLR_ON_B) && b_rise; // RQ4 RQ5

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      count_value_q <= '0;
    end else if (pin_clear) begin
      count_value_q <= '0; // RQ4
    end else if (clr_en_q && match_b) begin
      count_value_q <= '0; // RQ7
    end else if (tick) begin
      count_value_q <= count_value_q + 16'h0001; // RQ13
    end
  end

  // ---------------- captures
  assign ff_rise = pulse_flipflop_q & ~pulse_ff_prev_q;
  assign ff_fall = ~pulse_flipflop_q & pulse_ff_prev_q;

  always_comb begin
    cap_a_ev = 1'b0;
    cap_b_ev = 1'b0;
    case (cap_sel_q)
      CAP_A_RISE_B_RISE: begin
        cap_a_ev = a_rise; // RQ1
        cap_b_ev = b_rise; // RQ1
      end
      CAP_A_RISE_A_FALL: begin
        cap_a_ev = a_rise; // RQ2
        cap_b_ev = a_fall; // RQ2
      end
      CAP_FF_RISE_FALL: begin
        cap_a_ev = ff_rise; // RQ3
        cap_b_ev = ff_fall; // RQ3
      end
      CAP_A_CLR_ON_B: begin
        cap_a_ev = a_rise; // RQ5
      end
      default: begin
        cap_a_ev = 1'b0; // RQ1
        cap_b_ev = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cap_a_q <= '0;
      cap_b_q <= '0;
    end else begin
      if (cap_a_ev || soft_cap) begin
        cap_a_q <= count_value_q; // RQ13
      end
      if (cap_b_ev) begin
        cap_b_q <= count_value_q;
      end
    end
  end

  // ---------------- pulse flip-flop; a write to control presets it
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_flipflop_q <= 1'b0;
      pulse_ff_prev_q <= 1'b0;
    end else begin
      pulse_ff_prev_q <= pulse_flipflop_q;
      if (wr_pend_q && wr_addr_q == OFS_CTRL) begin
        pulse_flipflop_q <= hwdata_i[FF_INIT_BIT];
      end else if (pulse_en_q && (match_a || match_b)) begin
        pulse_flipflop_q <= ~pulse_flipflop_q; // RQ9
      end
    end
  end

  // polarity picks whether the flip-flop or its inverse reaches the pin
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_out_pin_o <= 1'b0;
    end else begin
      pulse_out_pin_o <= act_high_q ? pulse_flipflop_q
                                    : ~pulse_flipflop_q; // RQ9 RQ10
    end
  end
endmodule

// ===== capture_timer_pkg.sv
// constants and types shared by the capture timer design
//
// Notes on behaviour
// RQ1 - capture timing 000 disables pin capture, 001 loads capture A on input a rise and capture B on input b rise.
// RQ2 - capture timing 010 loads capture A on input a rise and capture B on input a fall.
// RQ3 - capture timing 011 loads capture A on pulse flip-flop rise and capture B on its fall.
// RQ4 - capture timing 100 clears the counter on each input b rise without capture; 110 and 111 are reserved.
// RQ5 - capture timing 101 loads capture A on input a rise and clears the counter on input b rise, capture first.
// RQ6 - writing zero to the soft capture bit copies the counter into capture A, one does nothing, and it reads one.
// RQ7 - with match clear enable set the counter clears when it equals compare B, otherwise it does not.
// RQ8 - count clock select 000 picks the external clock pin, 001 to 111 pick prescaler taps 1,4,16,32,64,128,256.
// RQ9 - in pulse mode the flip-flop toggles on counter equal compare A and on counter equal compare B, and drives the pin.
// RQ10 - the pulse output can be set active low or active high.
// RQ11 - software must keep compare A strictly below compare B in pulse mode.
// RQ12 - with double buffering in pulse mode, buffers 0 and 1 move into compare A and B when the counter matches compare B.
// RQ13 - the counter advances by one on each selected count tick and captures take the counter value of that tick.
package capture_timer_pkg;
  localparam int CNT_W = 16;
  localparam int ADDR_W = 8;

  // byte offsets of the word registers
  localparam logic [ADDR_W-1:0] OFS_MODE = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMPA = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CMPB = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CAPA = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_CAPB = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_CNT = 8'h18;

  // timer_mode fields
  localparam int CLK_SEL_LSB = 0;
  localparam int CLR_EN_BIT = 3;
  localparam int SOFT_CAP_BIT = 6;
  localparam int CAP_SEL_LSB = 8;
  localparam logic [31:0] MODE_RESET = 32'h0000_0040;

  // control register fields
  localparam int RUN_BIT = 0;
  localparam int PULSE_EN_BIT = 1;
  localparam int DBUF_EN_BIT = 2;
  localparam int ACT_HIGH_BIT = 3;
  localparam int FF_INIT_BIT = 4;

  typedef enum logic [2:0] {
    CAP_OFF = 3'h0,
    CAP_A_RISE_B_RISE = 3'h1,
    CAP_A_RISE_A_FALL = 3'h2,
    CAP_FF_RISE_FALL = 3'h3,
    CAP_CLR_ON_B = 3'h4,
    CAP_A_CLR_ON_B = 3'h5
  } cap_sel_t;

  localparam logic [2:0] CLK_EXT_PIN = 3'h0;
  localparam int PRESC_W = 8;
endpackage

// ===== edge_sync.sv
// two-stage synchroniser with rise and fall pulses
`timescale 1ns/10ps
module edge_sync (
  input  wire logic clk_sys_i,
  input  wire logic rst_b_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end else begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;
endmodule

// ===== prescaler.sv
// prescaler, held at zero while stopped, producing the count tick for a selected tap
`timescale 1ns/10ps
module prescaler
  import capture_timer_pkg::*;
(
  input  wire logic       clk_sys_i,
  input  wire logic       rst_b_i,
  input  wire logic       run_i,
  input  wire logic [2:0] sel_i,
  input  wire logic       ext_rise_i,
  output logic            tick_o
);
  logic [PRESC_W-1:0] div_q;

  // a tap divided by 2^k ticks when the low k bits are all ones
  function automatic logic tap_hit(input logic [2:0] s,
                                   input logic [PRESC_W-1:0] d);
    logic [PRESC_W-1:0] m;
    m = '0;
    case (s)
      3'h1:    m = 8'h00;
      3'h2:    m = 8'h03;
      3'h3:    m = 8'h0F;
      3'h4:    m = 8'h1F;
      3'h5:    m = 8'h3F;
      3'h6:    m = 8'h7F;
      default: m = 8'hFF;
    endcase
    tap_hit = ((d & m) == m);
  endfunction

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_q <= '0;
    end else if (!run_i) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign tick_o = run_i & ((sel_i == CLK_EXT_PIN) ? ext_rise_i
                          : tap_hit(sel_i, div_q)); // RQ8
endmodule

// ===== capture_timer_monitor.sv
// assertion checker for the capture timer register port
`timescale 1ns/10ps
module capture_timer_monitor
  import capture_timer_pkg::*;
(
  input wire logic        clk_sys_i,
  input wire logic        rst_b_i,
  input wire logic        hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0]  htrans_i,
  input wire logic        hwrite_i,
  input wire logic        hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic        hreadyout_o,
  input wire logic        hresp_o
);
  logic       req;
  logic       dph_q;
  logic       rd_q;
  logic [7:0] adr_q;
  assign req = hsel_i & hready_i & htrans_i[1];
  // data phase tracking, so read data is judged only where it stands
  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dph_q <= 1'b0;
      rd_q  <= 1'b0;
      adr_q <= 8'h00;
    end else begin
      dph_q <= req;
      rd_q  <= ~hwrite_i;
      adr_q <= haddr_i[7:0];
    end
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_b_i);
  a_ready_high: assert property (hreadyout_o == 1'b1)
    else $error("hreadyout dropped");
  a_resp_okay: assert property (req |=> (!hresp_o) [*2])
    else $error("response not okay");
  a_rdata_idle: assert property (!dph_q |-> hrdata_o == 32'h0000_0000)
    else $error("read data outside data phase");
  a_soft_reads_one: assert property (
    dph_q && rd_q && adr_q == OFS_MODE |-> hrdata_o[SOFT_CAP_BIT])
    else $error("soft capture bit read as zero");
  a_mode_rsvd_zero: assert property (dph_q && rd_q && adr_q == OFS_MODE
    |-> hrdata_o[31:11] == 21'h0 && hrdata_o[7:4] == 4'h4)
    else $error("mode reserved bits not zero");
  a_count_16bit: assert property (req && !hwrite_i &&
    haddr_i[7:0] >= OFS_CAPA && haddr_i[7:0] <= OFS_CNT
    |=> hrdata_o[31:16] == 16'h0000)
    else $error("counter value wider than 16 bits");
  a_unmapped_zero: assert property (req && !hwrite_i &&
    haddr_i[7:0] > OFS_CNT ##1 dph_q |-> hrdata_o == 32'h0000_0000)
    else $error("unmapped read not zero");
  a_ctrl_rsvd_zero: assert property (dph_q && rd_q && adr_q == OFS_CTRL
    |-> hrdata_o[31:5] == 27'h0)
    else $error("control reserved bits not zero");
endmodule
bind capture_timer capture_timer_monitor mon_u (
  .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i),
  .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
  .hready_i(hready_i), .hrdata_o(hrdata_o),
  .hreadyout_o(hreadyout_o), .hresp_o(hresp_o)
);

// ===== tb_capture_timer.sv
// self-checking bench for the capture timer
`timescale 1ns/10ps
module tb_capture_timer;
  import capture_timer_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic        hsel      = 1'b0;
  logic        hwrite    = 1'b0;
  logic [1:0]  htrans    = 2'h0;
  logic [31:0] haddr     = 32'h0000_0000;
  logic [31:0] hwdata    = 32'h0000_0000;
  logic        pin_a     = 1'b0;
  logic        pin_b     = 1'b0;
  logic        pin_ext   = 1'b0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hresp;
  logic        pulse;
  logic [31:0] v;
  logic [31:0] c0;
  logic [31:0] c1;
  int          k;
  int          failures   = 0;
  int          n_compared = 0;
  always #25 clk_sys_i = ~clk_sys_i;
  capture_timer dut_u (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
    .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .capture_input_a_i(pin_a), .capture_input_b_i(pin_b),
    .ext_count_clock_pin_i(pin_ext), .pulse_out_pin_o(pulse));
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic cmp(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_rng(input string nm, input logic [31:0] lo, hi, g);
    n_compared++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      failures++;
      $display("CHECK FAILED %s exp %0d..%0d got %0d", nm, lo, hi, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (hready !== 1'b1 && n < 64);
    if (n >= 64) begin
      failures++;
      end_sim();
    end
  endtask
  // address phase held until hready, then data phase held until hready
  task automatic xfer(input logic w, input logic [7:0] a, input [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    v = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask
  task automatic pins(input logic a, b);
    pin_a <= a;
    pin_b <= b;
    cyc(6);
  endtask
  // counter left stopped, so captures can be predicted exactly
  task automatic run_stop(input int n);
    wr(OFS_CTRL, 32'h0000_0001);
    cyc(n);
    wr(OFS_CTRL, 32'h0000_0000);
    rd(OFS_CNT);
  endtask
  // toggle mode keeps state, so restart from count 0 with the ff preset
  task automatic restart(input logic [31:0] ctl);
    wr(OFS_CTRL, 32'h0000_0000);
    wr(OFS_MODE, 32'h0000_0441);
    pins(1'b0, 1'b1);
    pins(1'b0, 1'b0);
    wr(OFS_MODE, 32'h0000_0349);
    wr(OFS_CTRL, ctl);
    cyc(40);
  endtask
  task automatic count_lvl(input logic lvl, input int n);
    k = 0;
    repeat (n) begin
      @(posedge clk_sys_i);
      if (pulse === lvl) k++;
    end
  endtask
  task automatic t_reset();
    rd(OFS_MODE);
    cmp("mode", MODE_RESET, v);
    rd(OFS_CNT);
    cmp("count", 32'h0000_0000, v);
    rd(8'h40);
    cmp("unmapped", 32'h0000_0000, v);
    rd(OFS_CTRL);
    cmp("control", 32'h0000_0000, v);
  endtask
  task automatic t_clock();
    int dv [7] = '{1, 4, 16, 32, 64, 128, 256};
    for (int i = 1; i < 8; i++) begin
      wr(OFS_MODE, 32'h0000_0040 | i);
      wr(OFS_CTRL, 32'h0000_0001);
      rd(OFS_CNT);
      c0 = v;
      cyc(512);
      rd(OFS_CNT);
      cmp_rng("ticks", 514 / dv[i-1], 514 / dv[i-1] + 1,
              (v - c0) & 32'h0000_FFFF);
    end
    wr(OFS_MODE, 32'h0000_0040);
    rd(OFS_CNT);
    c0 = v;
    repeat (5) begin
      pin_ext <= 1'b1;
      cyc(4);
      pin_ext <= 1'b0;
      cyc(4);
    end
    rd(OFS_CNT);
    cmp("ext ticks", 32'h0000_0005, (v - c0) & 32'h0000_FFFF);
  endtask
  task automatic t_clear();
    wr(OFS_CMPB, 32'h0000_0014);
    restart(32'h0000_0001);
    repeat (8) begin
      cyc(7);
      rd(OFS_CNT);
      cmp_rng("cleared count", 0, 20, v);
    end
  endtask
  task automatic t_capture();
    wr(OFS_MODE, 32'h0000_0141);
    run_stop(30);
    c0 = v;
    pins(1'b1, 1'b0);
    rd(OFS_CAPA);
    cmp("cap a", c0, v);
    pins(1'b1, 1'b1);
    rd(OFS_CAPB);
    cmp("cap b", c0, v);
    pins(1'b0, 1'b0);
    wr(OFS_MODE, 32'h0000_0041);
    run_stop(30);
    pins(1'b1, 1'b1);
    rd(OFS_CAPA);
    cmp("cap a off", c0, v);
    pins(1'b0, 1'b0);
    wr(OFS_MODE, 32'h0000_0241);
    run_stop(30);
    c0 = v;
    pins(1'b1, 1'b0);
    rd(OFS_CAPA);
    cmp("cap a rise", c0, v);
    run_stop(30);
    c1 = v;
    pins(1'b0, 1'b0);
    rd(OFS_CAPB);
    cmp("cap b fall", c1, v);
    run_stop(30);
    c0 = v;
    wr(OFS_MODE, 32'h0000_0001);
    rd(OFS_CAPA);
    cmp("soft cap", c0, v);
    run_stop(30);
    wr(OFS_MODE, 32'h0000_0441);
    rd(OFS_CAPA);
    cmp("soft cap one", c0, v);
    pins(1'b0, 1'b1);
    rd(OFS_CNT);
    cmp("clear on b", 32'h0000_0000, v);
    rd(OFS_CAPB);
    cmp("no cap on clear", c1, v);
    pins(1'b0, 1'b0);
    wr(OFS_MODE, 32'h0000_0541);
    run_stop(30);
    c0 = v;
    pins(1'b1, 1'b1);
    rd(OFS_CAPA);
    cmp("cap before clear", c0, v);
    rd(OFS_CNT);
    cmp("clear after cap", 32'h0000_0000, v);
    pins(1'b0, 1'b0);
  endtask
  task automatic t_pulse();
    wr(OFS_CMPA, 32'h0000_0005);
    wr(OFS_CMPB, 32'h0000_000A);
    restart(32'h0000_0003);
    count_lvl(1'b0, 110);
    cmp("low time", 32'd50, k);
    rd(OFS_CAPA);
    c0 = v;
    rd(OFS_CAPB);
    cmp("ff capture gap", 32'h0000_0005, (v + 11 - c0) % 11);
    restart(32'h0000_000B);
    count_lvl(1'b1, 110);
    cmp("high time", 32'd50, k);
    restart(32'h0000_0007);
    wr(OFS_CMPA, 32'h0000_0002);
    wr(OFS_CMPB, 32'h0000_0014);
    cyc(60);
    count_lvl(1'b0, 210);
    cmp("buffered low time", 32'd180, k);
  endtask
  initial begin
    cyc(16);
    rst_b_i <= 1'b1;
    @(posedge clk_sys_i);
    t_reset();
    t_clock();
    t_clear();
    t_capture();
    t_pulse();
    end_sim();
  end
endmodule
